// *** hw/seq_defines.vh ***
`ifndef SEQ_DEFINES_VH
`define SEQ_DEFINES_VH

// ****************************************************************
// Register map (byte addresses)
// ****************************************************************
`define ADDR_W         8
`define ADDR_MODE      8'h00
`define ADDR_LOAD      8'h04
`define ADDR_HOLD      8'h08
`define ADDR_CMD       8'h0C
`define ADDR_STATUS    8'h10
`define ADDR_COUNT     8'h14
`define ADDR_CTRL      8'h18

// ****************************************************************
// Mode register fields
// ****************************************************************
`define MODE_RESET     16'h0000
`define MODE_GCTL_HI   15
`define MODE_GCTL_LO   13
`define MODE_SPECIAL   7
`define MODE_RELOAD    6
`define MODE_REPEAT    5
`define MODE_TOGGLE    0

// ****************************************************************
// Gate control field encodings
// ****************************************************************
`define GCTL_NONE      3'h0
`define GCTL_LVL_HIGH  3'h1
`define GCTL_LVL_LOW   3'h2
`define GCTL_EDG_RISE  3'h3
`define GCTL_EDG_FALL  3'h4

// ****************************************************************
// Command, control and status fields
// ****************************************************************
`define CMD_ARM        0
`define CMD_DISARM     1
`define CTRL_FIX       0
`define CTRL_RESET     1'b0
`define ST_ARMED       0
`define ST_COUNTING    1
`define ST_PHASE       2
`define ST_OUT         3
`define ST_WAITING     4

// ****************************************************************
// Counter constants
// ****************************************************************
`define CNT_W          16
`define CNT_RESET      16'h0000
`define CNT_END_VAL    16'h0001
`define CNT_REFUSED    16'h0001
`define CNT_STEP       16'h0001

// ****************************************************************
// Bus answers
// ****************************************************************
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`define DATA_ZERO      32'h00000000
`define HALF_ZERO      16'h0000
`define STRB_NONE      4'h0

`endif

// *** hw/counter_mode_sequencer.v ***
// Notes on behaviour
// - With reload bit clear, each count end reloads from the load register.
// - Reload bit set, special gate clear: alternate load and hold at each count end.
// - Repeat set counts on forever; clear stops after one, or two alternating, cycles.
// - Gate field zero ignores gate; level setting counts while active; edge triggers.
// - Edge-gated one-cycle modes start one count sequence on the first valid gate edge after arm.
// - Edge-gated alternating modes run load then hold count per gate edge.
// - Mode A counts after arm, reloads from load, then disarms.
// - Mode B counts only while gate active, pauses otherwise; reload and disarm.
// - Mode C starts on gate edge, ignores further gate, idles until rearmed.
// - Mode D counts and reloads from load repeatedly until disarmed.
// - Mode D counting is not influenced by the gate at all.
// - Mode D with toggle output inverts output at each count end.
// - Mode E counts repetitively, reloading from load, only while gate asserted.
// - Mode F starts one count per gate edge without a new arm.
// - Mode F ignores gate edges arriving while a count runs.
// - Mode G counts load value, reloads from hold, counts hold value.
// - Mode G disarms and reloads from load after the second count end.
// - Mode G toggle output gives one pulse: load sets delay, hold sets width.
// - Gate-selected reload should follow gate; this revision uses hold unless the fix bit is set.
// - This revision refuses a count value of one in load or hold.
// - Mode S reloads from hold when gate high, from load when gate low.
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`include "seq_defines.vh"

module counter_mode_sequencer (
   // Clock and reset
   input  wire                 aclk,
   input  wire                 aresetn,
   // Write address channel
   input  wire                 s_axi_awvalid,
   output wire                 s_axi_awready,
   input  wire [`ADDR_W-1:0]   s_axi_awaddr,
   input  wire [2:0]           s_axi_awprot,
   // Write data channel
   input  wire                 s_axi_wvalid,
   output wire                 s_axi_wready,
   input  wire [31:0]          s_axi_wdata,
   input  wire [3:0]           s_axi_wstrb,
   // Write response channel
   output wire                 s_axi_bvalid,
   input  wire                 s_axi_bready,
   output wire [1:0]           s_axi_bresp,
   // Read address channel
   input  wire                 s_axi_arvalid,
   output wire                 s_axi_arready,
   input  wire [`ADDR_W-1:0]   s_axi_araddr,
   input  wire [2:0]           s_axi_arprot,
   // Read data channel
   output wire                 s_axi_rvalid,
   input  wire                 s_axi_rready,
   output wire [31:0]          s_axi_rdata,
   output wire [1:0]           s_axi_rresp,
   // Counter side
   input  wire                 count_tick,
   input  wire                 gate_in,
   output wire                 count_end,
   output wire                 count_out
);

   localparam [2:0] ST_IDLE  = 3'b001;
   localparam [2:0] ST_WAIT  = 3'b010;
   localparam [2:0] ST_COUNT = 3'b100;

   // ****************************************************************
   // Register bus slave
   // ****************************************************************
   // Write and read channels run independently, so a read may be answered
   // while a write still waits for its response to be taken.
   reg                 aw_full_reg;
   reg [`ADDR_W-1:0]   aw_addr_reg;
   reg                 w_full_reg;
   reg [31:0]          w_data_reg;
   reg [3:0]           w_strb_reg;
   reg                 bvalid_reg;
   reg [1:0]           bresp_reg;
   reg                 rvalid_reg;
   reg [31:0]          rdata_reg;
   reg [1:0]           rresp_reg;
   reg [15:0]          mode_reg;
   reg [`CNT_W-1:0]    load_reg;
   reg [`CNT_W-1:0]    hold_reg;
   reg                 fix_reg;
   reg [2:0]           state_reg;
   reg [2:0]           state_next;
   reg                 phase_reg;
   reg                 phase_next;
   reg [`CNT_W-1:0]    cnt_reg;
   reg [`CNT_W-1:0]    cnt_next;
   reg                 out_reg;
   reg                 out_next;
   reg                 end_reg;
   reg                 end_next;
   reg                 gate_prev_reg;
   reg [31:0]          rd_mux;
   reg [31:0]          status_word;
   reg                 rd_hit;
   reg                 wr_hit;
   reg [`CNT_W-1:0]    reload_val;
   reg [2:0]           after_end;

   wire                do_write;
   wire                ar_take;
   wire [15:0]         wr_merge16;
   wire                arm_cmd;
   wire                disarm_cmd;

   function [15:0] merge16;
      input [15:0] old_val;
      input [31:0] data;
      input [3:0]  strb;
      begin
         merge16 = {strb[1] ? data[15:8] : old_val[15:8],
                    strb[0] ? data[7:0]  : old_val[7:0]};
      end
   endfunction

   assign s_axi_awready = ~aw_full_reg & ~bvalid_reg;
   assign s_axi_wready  = ~w_full_reg & ~bvalid_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = ~rvalid_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;

   assign do_write   = aw_full_reg & w_full_reg & ~bvalid_reg;
   assign ar_take    = s_axi_arvalid & ~rvalid_reg;
   assign wr_merge16 = (aw_addr_reg == `ADDR_LOAD) ? merge16(load_reg, w_data_reg, w_strb_reg) :
                       (aw_addr_reg == `ADDR_HOLD) ? merge16(hold_reg, w_data_reg, w_strb_reg) :
                       merge16(mode_reg, w_data_reg, w_strb_reg);
   // Both command bits in one write leave the counter idle: disarm wins.
   assign arm_cmd    = do_write & (aw_addr_reg == `ADDR_CMD) & w_strb_reg[0] &
                       w_data_reg[`CMD_ARM];
   assign disarm_cmd = do_write & (aw_addr_reg == `ADDR_CMD) & w_strb_reg[0] &
                       w_data_reg[`CMD_DISARM];

   // ****************************************************************
   // Write decode
   // ****************************************************************
   // Writes to read-only or unmapped words are answered with an error
   // and change nothing.
   always @* begin
      case (aw_addr_reg)
         `ADDR_MODE, `ADDR_LOAD, `ADDR_HOLD, `ADDR_CMD, `ADDR_CTRL: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // ****************************************************************
   // Status word
   // ****************************************************************
   // Spare bits read as zero, so fields added later do not disturb
   // drivers that test the word as a whole.
   always @* begin
      status_word               = `DATA_ZERO;
      status_word[`ST_ARMED]    = (state_reg != ST_IDLE);
      status_word[`ST_COUNTING] = (state_reg == ST_COUNT);
      status_word[`ST_PHASE]    = phase_reg;
      status_word[`ST_OUT]      = out_reg;
      status_word[`ST_WAITING]  = (state_reg == ST_WAIT);
   end

   // ****************************************************************
   // Read mux
   // ****************************************************************
   always @* begin
      rd_hit = 1'b1;
      case (s_axi_araddr)
         `ADDR_MODE:   rd_mux = {`HALF_ZERO, mode_reg};
         `ADDR_LOAD:   rd_mux = {`HALF_ZERO, load_reg};
         `ADDR_HOLD:   rd_mux = {`HALF_ZERO, hold_reg};
         `ADDR_CMD:    rd_mux = `DATA_ZERO;
         `ADDR_STATUS: rd_mux = status_word;
         `ADDR_COUNT:  rd_mux = {`HALF_ZERO, cnt_reg};
         `ADDR_CTRL:   rd_mux = {31'h00000000, fix_reg};
         default: begin
            rd_mux = `DATA_ZERO;
            rd_hit = 1'b0;
         end
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_reg <= 1'b0;
         aw_addr_reg <= {`ADDR_W{1'b0}};
         w_full_reg  <= 1'b0;
         w_data_reg  <= `DATA_ZERO;
         w_strb_reg  <= `STRB_NONE;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= `RESP_OKAY;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= `DATA_ZERO;
         rresp_reg   <= `RESP_OKAY;
         mode_reg    <= `MODE_RESET;
         load_reg    <= `CNT_RESET;
         hold_reg    <= `CNT_RESET;
         fix_reg     <= `CTRL_RESET;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            bvalid_reg  <= 1'b1;
            bresp_reg   <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            case (aw_addr_reg)
               `ADDR_MODE: mode_reg <= wr_merge16;
               `ADDR_LOAD: begin
                  // A count of one is silently kept out; the old value stays.
                  if (wr_merge16 != `CNT_REFUSED)
                     load_reg <= wr_merge16;
               end
               `ADDR_HOLD: begin
                  if (wr_merge16 != `CNT_REFUSED)
                     hold_reg <= wr_merge16;
               end
               `ADDR_CTRL: begin
                  if (w_strb_reg[0])
                     fix_reg <= w_data_reg[`CTRL_FIX];
               end
               default: begin
               end
            endcase
         end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
         if (ar_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_mux;
            rresp_reg  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
         end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Mode decode and gating
   // ****************************************************************
   wire [2:0] gctl      = mode_reg[`MODE_GCTL_HI:`MODE_GCTL_LO];
   wire       special   = mode_reg[`MODE_SPECIAL];
   wire       reload_b  = mode_reg[`MODE_RELOAD];
   wire       repeat_b  = mode_reg[`MODE_REPEAT];
   wire       toggle_b  = mode_reg[`MODE_TOGGLE];
   wire       gate_none = (gctl == `GCTL_NONE);
   wire       gate_lvl_mode  = (gctl == `GCTL_LVL_HIGH) | (gctl == `GCTL_LVL_LOW);
   wire       gate_edge_mode = (gctl == `GCTL_EDG_RISE) | (gctl == `GCTL_EDG_FALL);
   wire       gate_level = (gctl == `GCTL_LVL_LOW) ? ~gate_in : gate_in;
   wire       gate_edge  = (gctl == `GCTL_EDG_RISE) ? (gate_in & ~gate_prev_reg) :
                           (gctl == `GCTL_EDG_FALL) ? (~gate_in & gate_prev_reg) : 1'b0;
   wire       alt_mode   = reload_b & ~special;
   // Only the gate-selected reload strobes with no gate gating are served
   // when the special gate bit is set; every other such setting stays idle.
   wire       gsel_mode  = special & reload_b & gate_none;
   // Gate codes five to seven are reserved; an arm with one of them is
   // refused rather than given a guessed meaning.
   wire       mode_ok    = (gate_none | gate_lvl_mode | gate_edge_mode) &
                           (~special | gsel_mode);
   wire       last_phase = (alt_mode | gsel_mode) ? phase_reg : 1'b1;
   // Level gating holds the count; no gating or a taken edge lets it run.
   wire       gate_ok    = gate_lvl_mode ? gate_level : 1'b1;

   always @* begin
      if (gsel_mode) begin
         // Setting the fix bit gives the intended gate selection; cleared,
         // the faulty always-hold reload of this revision is reproduced.
         if (fix_reg)
            reload_val = gate_in ? hold_reg : load_reg;
         else
            reload_val = hold_reg;
      end else if (alt_mode && !phase_reg) begin
         reload_val = hold_reg;
      end else begin
         reload_val = load_reg;
      end
   end

   // An edge-gated repeating mode goes back to waiting, still armed, so
   // the next valid gate edge starts it again without software.
   always @* begin
      if (!repeat_b && last_phase)
         after_end = ST_IDLE;
      else if (repeat_b && last_phase && gate_edge_mode)
         after_end = ST_WAIT;
      else
         after_end = ST_COUNT;
   end

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   always @* begin
      state_next = state_reg;
      phase_next = phase_reg;
      cnt_next   = cnt_reg;
      end_next   = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (arm_cmd && !disarm_cmd && mode_ok) begin
               cnt_next   = load_reg;
               phase_next = 1'b0;
               state_next = gate_edge_mode ? ST_WAIT : ST_COUNT;
            end
         end
         ST_WAIT: begin
            if (disarm_cmd)
               state_next = ST_IDLE;
            else if (gate_edge)
               state_next = ST_COUNT;
         end
         ST_COUNT: begin
            // Gate edges are not looked at here, so a running count is
            // never restarted by the gate.
            if (disarm_cmd) begin
               state_next = ST_IDLE;
            end else if (count_tick && gate_ok) begin
               if (cnt_reg == `CNT_END_VAL) begin
                  end_next   = 1'b1;
                  cnt_next   = reload_val;
                  phase_next = (alt_mode | gsel_mode) ? ~phase_reg : 1'b0;
                  state_next = after_end;
               end else begin
                  // A load of zero wraps through the full range, the longest count.
                  cnt_next = cnt_reg - `CNT_STEP;
               end
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      out_next = toggle_b ? (out_reg ^ end_next) : end_next;
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         state_reg     <= ST_IDLE;
         phase_reg     <= 1'b0;
         cnt_reg       <= `CNT_RESET;
         out_reg       <= 1'b0;
         end_reg       <= 1'b0;
         // A gate held high through reset looks like a rising edge here; it
         // is harmless, since nothing waits for an edge until a bus write
         // has armed the counter.
         gate_prev_reg <= 1'b0;
      end else begin
         state_reg     <= state_next;
         phase_reg     <= phase_next;
         cnt_reg       <= cnt_next;
         out_reg       <= out_next;
         end_reg       <= end_next;
         gate_prev_reg <= gate_in;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign count_end = end_reg;
   assign count_out = out_reg;

endmodule

// *** sim/seq_monitor.sv ***
`timescale 1ns/10ps
`include "seq_defines.vh"

// ************************************************************
// Bus handshake and count end checks
// ************************************************************
module seq_monitor (
   // Clock and reset
   input wire        aclk,
   input wire        aresetn,
   // Register bus
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire [31:0] s_axi_rdata,
   // Counter side
   input wire        count_tick,
   input wire        count_end
);
   default clocking mon_cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp))
      else $error("write answer dropped");
   chk_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata))
      else $error("read answer dropped");
   chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   // A refused count of one means no two count ends can be adjacent.
   chk_end_single: assert property (count_end |=> !count_end)
      else $error("count end longer than one cycle");
   chk_end_cause: assert property (count_end |-> $past(count_tick))
      else $error("count end without a tick");

   cover property (count_end);
   cover property (s_axi_bvalid && s_axi_bresp == `RESP_SLVERR);
   cover property (s_axi_rvalid && !s_axi_rready);
endmodule

// *** sim/tick_gate_source.sv ***
`timescale 1ns/10ps

// ************************************************************
// Count source and gate driver
// ************************************************************
module tick_gate_source (
   // Clock shared with the host bus
   input  wire  aclk,
   // Counter side
   input  wire  count_end,
   output logic count_tick,
   output logic gate_in
);
   int ends = 0;

   initial begin
      count_tick = 1'b0;
      gate_in = 1'b0;
   end

   always @(posedge aclk) begin
      if (count_end) ends <= ends + 1;
   end

   // Ticks come every other cycle, so the counter also sees idle cycles.
   task ticks(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge aclk);
         count_tick <= 1'b1;
         @(posedge aclk);
         count_tick <= 1'b0;
      end
      repeat (3) @(posedge aclk);
   endtask

   task gate(input logic v);
      @(posedge aclk);
      gate_in <= v;
      repeat (2) @(posedge aclk);
   endtask
endmodule

// *** sim/counter_mode_sequencer_tb_top.sv ***
`timescale 1ns/10ps
`include "seq_defines.vh"

// ************************************************************
// Bench
// ************************************************************
module counter_mode_sequencer_tb_top;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'hF;
   logic [2:0]  prot = 3'h0;
   wire         awready, wready, bvalid, arready, rvalid;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire         count_tick, gate_in, count_end, count_out;
   logic        o;
   int          bad_count = 0;
   int          checked = 0;

   counter_mode_sequencer dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_awaddr(awaddr), .s_axi_awprot(prot), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
      .s_axi_arprot(prot), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .count_tick(count_tick),
      .gate_in(gate_in), .count_end(count_end), .count_out(count_out));
   tick_gate_source far (.aclk(aclk), .count_end(count_end), .count_tick(count_tick),
      .gate_in(gate_in));

   initial begin
      forever #10 aclk = ~aclk;
   end

   task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Handshakes are sampled at the rising edge, before that edge's updates land.
   task acc(input bit w, input [7:0] a, input [31:0] d, input [31:0] e = 32'h0,
            input [1:0] er = `RESP_OKAY, input [3:0] s = 4'hF);
      logic [31:0] q;
      logic [1:0]  r;
      bit          dn;
      dn = 1'b0;
      q = 32'h0;
      r = 2'h0;
      @(posedge aclk);
      if (w) begin
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         awaddr <= a;
         wdata <= d;
         wstrb <= s;
         bready <= 1'b1;
      end else begin
         arvalid <= 1'b1;
         araddr <= a;
         rready <= 1'b1;
      end
      while (!dn) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (arvalid && arready) arvalid <= 1'b0;
         dn = w ? bvalid : rvalid;
         r = w ? bresp : rresp;
         q = rdata;
      end
      bready <= 1'b0;
      rready <= 1'b0;
      cmp("answer", 32'h1, dn);
      if (!w) cmp("rdata", e, q);
      cmp("resp", er, r);
   endtask

   task run(input int n, input int e);
      int s;
      s = far.ends;
      far.ticks(n);
      cmp("ends", e, far.ends - s);
   endtask

   task start(input [31:0] m);
      acc(1, `ADDR_MODE, m);
      acc(1, `ADDR_CMD, 32'h1);
   endtask

   task t_regs;
      acc(0, `ADDR_STATUS, 32'h0, 32'h0);
      acc(0, `ADDR_COUNT, 32'h0, 32'h0);
      acc(1, 8'h1C, 32'h5, 32'h0, `RESP_SLVERR);
      acc(0, 8'h1C, 32'h0, 32'h0, `RESP_SLVERR);
      acc(1, `ADDR_LOAD, 32'h3);
      acc(1, `ADDR_LOAD, 32'h1);
      acc(0, `ADDR_LOAD, 32'h0, 32'h3);
      acc(1, `ADDR_HOLD, 32'h5634, 32'h0, `RESP_OKAY, 4'h1);
      acc(1, `ADDR_HOLD, 32'h1);
      acc(0, `ADDR_HOLD, 32'h0, 32'h34);
      acc(1, `ADDR_HOLD, 32'h2);
      $display("test regs done");
   endtask

   task t_once;
      start(32'h0000);
      run(3, 1);
      run(4, 0);
      acc(0, `ADDR_COUNT, 32'h0, 32'h3);
      acc(0, `ADDR_STATUS, 32'h0, 32'h0);
      far.gate(1'b0);
      start(32'h2000);
      run(4, 0);
      far.gate(1'b1);
      run(3, 1);
      run(3, 0);
      $display("test once done");
   endtask

   task t_edge;
      far.gate(1'b0);
      start(32'h6000);
      run(3, 0);
      far.gate(1'b1);
      run(3, 1);
      far.gate(1'b0);
      far.gate(1'b1);
      run(3, 0);
      $display("test edge done");
   endtask

   task t_rate;
      o = count_out;
      start(32'h0021);
      run(3, 1);
      far.gate(1'b0);
      run(6, 2);
      cmp("out", !o, count_out);
      acc(1, `ADDR_CMD, 32'h2);
      run(3, 0);
      far.gate(1'b1);
      start(32'h2020);
      run(6, 2);
      far.gate(1'b0);
      run(6, 0);
      acc(1, `ADDR_CMD, 32'h2);
      $display("test rate done");
   endtask

   task t_oneshot;
      start(32'h6020);
      far.gate(1'b1);
      run(1, 0);
      far.gate(1'b0);
      far.gate(1'b1);
      run(2, 1);
      run(3, 0);
      far.gate(1'b0);
      far.gate(1'b1);
      run(3, 1);
      acc(1, `ADDR_CMD, 32'h2);
      $display("test oneshot done");
   endtask

   task t_pair;
      o = count_out;
      start(32'h0041);
      run(3, 1);
      acc(0, `ADDR_COUNT, 32'h0, 32'h2);
      cmp("out", !o, count_out);
      run(2, 1);
      cmp("out", o, count_out);
      run(4, 0);
      acc(0, `ADDR_COUNT, 32'h0, 32'h3);
      far.gate(1'b0);
      start(32'h6040);
      run(3, 0);
      far.gate(1'b1);
      run(5, 2);
      run(3, 0);
      $display("test pair done");
   endtask

   task t_special;
      for (int f = 0; f < 2; f++) begin
         acc(1, `ADDR_CTRL, f);
         far.gate(1'b0);
         start(32'h00C0);
         run(3, 1);
         acc(0, `ADDR_COUNT, 32'h0, f ? 32'h3 : 32'h2);
         far.gate(1'b1);
         run(f ? 3 : 2, 1);
         acc(0, `ADDR_COUNT, 32'h0, 32'h2);
         acc(1, `ADDR_CMD, 32'h2);
      end
      start(32'h0080);
      acc(0, `ADDR_STATUS, 32'h0, 32'h0);
      run(3, 0);
      $display("test special done");
   endtask

   task complete_run;
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs;
      t_once;
      t_edge;
      t_rate;
      t_oneshot;
      t_pair;
      t_special;
      complete_run;
   end

   // The whole run needs under a thousand cycles; this leaves wide margin.
   initial begin
      #200000;
      bad_count++;
      complete_run;
   end
endmodule

bind counter_mode_sequencer seq_monitor mon (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .count_tick(count_tick), .count_end(count_end));
